// ===== verilog/irsu_top.sv
// Function
// - No interrupt is taken while global enable bit 7 is zero.
// - Taking an interrupt clears global enable; interrupt return sets it.
// - Set and clear instructions write the global enable bit.
// - Bit 6 stores one bit via bit-store, read back by bit-load.
// - Bit 4 always equals negative XOR overflow.
// - Flags: half 5, overflow 3, negative 2, zero 1, carry 0.
// - Stack pointer falls by one per byte, two per return address.
// - Stack pointer rises by one per byte, two per return address.
// - A source needs its own enable and the global enable.
// - Vectors 0x001..0x00B in the fixed source order.
// - Lowest vector address wins among simultaneous requests.
// - Reset from power-on, pin, watchdog or brown-out.
// - Pin low over 50 ns resets only when the disable fuse is one.
// - Watchdog expiry resets only while the watchdog is enabled.
// - Reset restores registers and restarts fetch at 0x000.
// - Power-down wake uses only the clock-counting start-up delay.
// - Watchdog reset is one cycle; delay starts at its end.
//
// Top of the interrupt, reset and status unit.
// Core drives instruction strobes in the CPU clock domain; pins are async.
`include "irsu_params.svh"
`default_nettype none
module irsu_top
   import irsu_pkg::*;
(
   input  wire logic        CLOCK_I,
   input  wire logic        NRST_I,
   input  wire logic        POR_I,
   input  wire logic        RESET_PIN_I,
   input  wire logic        RESET_PIN_DISABLE_FUSE_I,
   input  wire logic        WDT_EXPIRE_I,
   input  wire logic        WDT_ENABLE_I,
   input  wire logic        BROWNOUT_I,
   input  wire logic        WAKE_POWERDOWN_I,
   input  wire logic [10:0] IRQ_PEND_I,
   input  wire logic [10:0] IRQ_ENABLE_I,
   input  wire logic        IO_WR_I,
   input  wire logic [5:0]  IO_ADDR_I,
   input  wire logic [7:0]  IO_WDATA_I,
   output logic [7:0]       IO_RDATA_O,
   input  wire logic        SET_GIE_I,
   input  wire logic        CLR_GIE_I,
   input  wire logic        IRET_I,
   input  wire logic        RET_I,
   input  wire logic        CALL_I,
   input  wire logic        PUSH_I,
   input  wire logic        POP_I,
   input  wire logic        BIT_STORE_I,
   input  wire logic        BIT_STORE_VAL_I,
   input  wire logic        FLAG_WR_I,
   input  wire logic        FLAG_HALF_I,
   input  wire logic        FLAG_OVF_I,
   input  wire logic        FLAG_NEG_I,
   input  wire logic        FLAG_ZERO_I,
   input  wire logic        FLAG_CARRY_I,
   input  wire logic        IRQ_ACCEPT_I,
   output logic [7:0]       STATUS_WORD_O,
   output logic [7:0]       STACK_PTR_O,
   output logic             TSTORE_O,
   output logic             IRQ_REQ_O,
   output logic [11:0]      IRQ_VECTOR_O,
   output logic             IRQ_TAKEN_O,
   output logic             CORE_RESET_O,
   output logic [11:0]      FETCH_ADDR_O,
   output logic             FETCH_LOAD_O,
   output logic             WDT_RESET_PULSE_O
);
   typedef struct packed {
      logic [2:0]  pin_sync;
      logic        pin_low;
      logic [7:0]  psw;
      logic [7:0]  sp;
      logic [7:0]  rdata;
      logic        taken;
      logic [11:0] fetch;
      logic        fload;
      logic        was_rst;
   } irsu_top_t;

   irsu_top_t   r;
   irsu_top_t   next_r;
   logic [1:0]  rst_sync;
   logic        rst_n;
   logic        core_rst;
   logic        wdt_pulse;
   irsu_sp_op_t sp_op;
   logic        take;
   logic        gie;
   irsu_arb_if  arb ();

   // Release the async reset through two flip-flops
   always_ff @(posedge CLOCK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         rst_sync <= 2'b00;
      end else begin
         rst_sync <= {rst_sync[0], 1'b1};
      end
   end
   assign rst_n = rst_sync[1];

   irsu_reset_ctl u_rst (
      .clk_i        (CLOCK_I),
      .rst_n_i      (rst_n),
      .por_i        (POR_I),
      .pin_low_i    (r.pin_low),
      .pin_dis_i    (!RESET_PIN_DISABLE_FUSE_I),
      .wdt_expire_i (WDT_EXPIRE_I),
      .wdt_en_i     (WDT_ENABLE_I),
      .bod_i        (BROWNOUT_I),
      .wake_i       (WAKE_POWERDOWN_I),
      .core_rst_o   (core_rst),
      .wdt_pulse_o  (wdt_pulse)
   );

   // Arbiter hookup
   assign gie = r.psw[`IRSU_BIT_IEN];
   assign arb.pend = IRQ_PEND_I;
   assign arb.en = IRQ_ENABLE_I;
   assign arb.gie = gie;
   irsu_arbiter u_arb (
      .arb (arb)
   );

   // Interrupt entry when the core accepts an offered request
   assign take = arb.req && IRQ_ACCEPT_I && !core_rst;

   // Stack step selection; interrupt entry and call push two bytes
   always_comb begin
      if (take || CALL_I) begin
         sp_op = IRSU_SP_PUSH2;
      end else if (RET_I || IRET_I) begin
         sp_op = IRSU_SP_POP2;
      end else if (PUSH_I) begin
         sp_op = IRSU_SP_PUSH1;
      end else if (POP_I) begin
         sp_op = IRSU_SP_POP1;
      end else begin
         sp_op = IRSU_SP_NONE;
      end
   end

   // Next-state logic
   always_comb begin
      next_r = r;
      // Pin passes three flops; low counts once stages 2 and 3 agree
      next_r.pin_sync = {r.pin_sync[1:0], RESET_PIN_I};
      if (r.pin_sync[2] == r.pin_sync[1]) begin
         next_r.pin_low = !r.pin_sync[2];
      end
      next_r.taken = 1'b0;
      next_r.fload = 1'b0;
      next_r.was_rst = core_rst;
      // Arithmetic flags from the ALU
      if (FLAG_WR_I) begin
         next_r.psw[`IRSU_BIT_HALF] = FLAG_HALF_I;
         next_r.psw[`IRSU_BIT_OVF] = FLAG_OVF_I;
         next_r.psw[`IRSU_BIT_NEG] = FLAG_NEG_I;
         next_r.psw[`IRSU_BIT_ZERO] = FLAG_ZERO_I;
         next_r.psw[`IRSU_BIT_CARRY] = FLAG_CARRY_I;
      end
      if (BIT_STORE_I) begin
         next_r.psw[`IRSU_BIT_TSTORE] = BIT_STORE_VAL_I;
      end
      if (SET_GIE_I) begin
         next_r.psw[`IRSU_BIT_IEN] = 1'b1;
      end
      if (CLR_GIE_I) begin
         next_r.psw[`IRSU_BIT_IEN] = 1'b0;
      end
      if (IRET_I) begin
         next_r.psw[`IRSU_BIT_IEN] = 1'b1;
      end
      // Stack pointer stepping
      unique case (sp_op)
         IRSU_SP_NONE:  next_r.sp = r.sp;
         IRSU_SP_PUSH1: next_r.sp = r.sp - 8'h01;
         IRSU_SP_PUSH2: next_r.sp = r.sp - 8'h02;
         IRSU_SP_POP1:  next_r.sp = r.sp + 8'h01;
         IRSU_SP_POP2:  next_r.sp = r.sp + 8'h02;
         default:       next_r.sp = r.sp;
      endcase
      // I/O writes from software
      if (IO_WR_I && IO_ADDR_I == `IRSU_SP_ADDR) begin
         next_r.sp = IO_WDATA_I;
      end
      if (IO_WR_I && IO_ADDR_I == `IRSU_PSW_ADDR) begin
         next_r.psw = IO_WDATA_I;
      end
      // Interrupt entry overrides any enable set in the same cycle
      if (take) begin
         next_r.psw[`IRSU_BIT_IEN] = 1'b0;
         next_r.taken = 1'b1;
         next_r.fetch = arb.vector;
         next_r.fload = 1'b1;
      end
      // Sign bit always derived
      next_r.psw[`IRSU_BIT_SIGN] =
         next_r.psw[`IRSU_BIT_NEG] ^ next_r.psw[`IRSU_BIT_OVF];
      // Read data port
      if (IO_ADDR_I == `IRSU_SP_ADDR) begin
         next_r.rdata = next_r.sp;
      end else if (IO_ADDR_I == `IRSU_PSW_ADDR) begin
         next_r.rdata = next_r.psw;
      end else begin
         next_r.rdata = 8'h00;
      end
      // Core reset restores status word, stack pointer and read data and points fetch at zero
      if (core_rst) begin
         next_r.psw = `IRSU_PSW_RESET;
         next_r.sp = `IRSU_SP_RESET;
         next_r.fetch = `IRSU_RESET_VECTOR;
         next_r.rdata = 8'h00;
      end else if (r.was_rst) begin
         next_r.fload = 1'b1;
      end
   end

   always_ff @(posedge CLOCK_I or negedge rst_n) begin
      if (!rst_n) begin
         r <= '{pin_sync: 3'b111, pin_low: 1'b0, psw: `IRSU_PSW_RESET,
                sp: `IRSU_SP_RESET, rdata: 8'h00, taken: 1'b0,
                fetch: `IRSU_RESET_VECTOR, fload: 1'b0, was_rst: 1'b1};
      end else begin
         r <= next_r;
      end
   end

   // Outputs
   assign IO_RDATA_O = r.rdata;
   assign STATUS_WORD_O = r.psw;
   assign STACK_PTR_O = r.sp;
   assign TSTORE_O = r.psw[`IRSU_BIT_TSTORE];
   assign IRQ_REQ_O = arb.req && !core_rst;
   assign IRQ_VECTOR_O = arb.vector;
   assign IRQ_TAKEN_O = r.taken;
   assign CORE_RESET_O = core_rst;
   assign FETCH_ADDR_O = r.fetch;
   assign FETCH_LOAD_O = r.fload;
   assign WDT_RESET_PULSE_O = wdt_pulse;
endmodule
`default_nettype wire

// ===== verilog/irsu_params.svh
// Constants for the interrupt and reset status unit.
// Included by the top, arbiter and reset controller design files; definitions only.
`ifndef IRSU_PARAMS_SVH
`define IRSU_PARAMS_SVH

// Register addresses in I/O space
`define IRSU_SP_ADDR        6'h3D
`define IRSU_PSW_ADDR       6'h3F
// Status word bit positions
`define IRSU_BIT_IEN        7
`define IRSU_BIT_TSTORE     6
`define IRSU_BIT_HALF       5
`define IRSU_BIT_SIGN       4
`define IRSU_BIT_OVF        3
`define IRSU_BIT_NEG        2
`define IRSU_BIT_ZERO       1
`define IRSU_BIT_CARRY      0
// Reset values
`define IRSU_SP_RESET       8'h00
`define IRSU_PSW_RESET      8'h00
`define IRSU_RESET_VECTOR   12'h000
// Interrupt sources (vectors 1..11)
`define IRSU_NUM_SRC        11
// Reset pin low time, ns, and the clock period, ns
`define IRSU_PIN_LOW_NS     50
`define IRSU_CLK_NS         20
// Least time rounds up to whole cycles
`define IRSU_PIN_LOW_CYC    ((`IRSU_PIN_LOW_NS + `IRSU_CLK_NS - 1) / `IRSU_CLK_NS)
// Start-up delay in cycles after a reset ends
`define IRSU_STARTUP_CYC    16
// Shortened clock-counting delay after power-down wake-up
`define IRSU_WAKE_CYC       6

`endif

// ===== verilog/irsu_pkg.sv
// Types shared by the interrupt and reset status unit.
// Compiled before every module of the unit.
`default_nettype none
package irsu_pkg;
   // Stack pointer step requests
   typedef enum logic [2:0] {
      IRSU_SP_NONE,
      IRSU_SP_PUSH1,
      IRSU_SP_PUSH2,
      IRSU_SP_POP1,
      IRSU_SP_POP2
   } irsu_sp_op_t;
   // Start-up sequencer states
   typedef enum logic [1:0] {
      IRSU_RST_HOLD,
      IRSU_RST_DELAY,
      IRSU_RST_RUN
   } irsu_rst_state_t;
endpackage
`default_nettype wire

// ===== verilog/irsu_arb_if.sv
// Interface between the top and the vector arbiter.
// Same clock domain on both ends.
`default_nettype none
interface irsu_arb_if;
   logic [10:0] pend;
   logic [10:0] en;
   logic        gie;
   logic        req;
   logic [11:0] vector;
   modport arb (input pend, input en, input gie, output req, output vector);
   modport top (output pend, output en, output gie, input req, input vector);
endinterface
`default_nettype wire

// ===== verilog/irsu_arbiter.sv
// Fixed-priority vector arbiter, lowest vector wins.
// Purely combinational; pend and enable come straight from the top's ports, gie from its status register.
`include "irsu_params.svh"
`default_nettype none
module irsu_arbiter
   import irsu_pkg::*;
(
   irsu_arb_if.arb arb
);
   logic [10:0] live;
   // Source gated by its own enable and the global enable
   assign live = arb.pend & arb.en & {11{arb.gie}};
   assign arb.req = |live;
   // Lowest set index first; source i sits at vector i+1
   always_comb begin
      arb.vector = `IRSU_RESET_VECTOR;
      for (int i = `IRSU_NUM_SRC - 1; i >= 0; i--) begin
         if (live[i]) begin
            arb.vector = 12'(i + 1);
         end
      end
   end
endmodule
`default_nettype wire

// ===== verilog/irsu_reset_ctl.sv
// Reset combiner and start-up delay sequencer.
// Pin input already synchronised; other sources are clock-domain levels.
`include "irsu_params.svh"
`default_nettype none
module irsu_reset_ctl
   import irsu_pkg::*;
(
   input  wire logic clk_i,
   input  wire logic rst_n_i,
   input  wire logic por_i,
   input  wire logic pin_low_i,
   input  wire logic pin_dis_i,
   input  wire logic wdt_expire_i,
   input  wire logic wdt_en_i,
   input  wire logic bod_i,
   input  wire logic wake_i,
   output logic      core_rst_o,
   output logic      wdt_pulse_o
);
   typedef struct packed {
      irsu_rst_state_t st;
      logic [4:0]      cnt;
      logic [2:0]      low;
      logic            wpulse;
      logic            wake;
   } irsu_rc_t;
   irsu_rc_t r;
   irsu_rc_t next_r;
   logic     pin_rst;
   logic     src;

   // Combine all reset sources
   always_comb begin
      next_r = r;
      pin_rst = 1'b0;
      // Count pin low time only when the pin is a reset pin
      if (pin_low_i && !pin_dis_i) begin
         if (r.low != 3'(`IRSU_PIN_LOW_CYC)) begin
            next_r.low = r.low + 3'd1;
         end
      end else begin
         next_r.low = 3'd0;
      end
      pin_rst = (r.low == 3'(`IRSU_PIN_LOW_CYC));
      // One-cycle watchdog pulse, only while enabled
      next_r.wpulse = wdt_expire_i && wdt_en_i && !r.wpulse;
      src = por_i || pin_rst || r.wpulse || bod_i;
      if (wake_i) begin
         next_r.wake = 1'b1;
      end
      unique case (r.st)
         IRSU_RST_HOLD: begin
            next_r.cnt = 5'd0;
            if (!src) begin
               next_r.st = IRSU_RST_DELAY;
            end
         end
         IRSU_RST_DELAY: begin
            next_r.cnt = r.cnt + 5'd1;
            if (src) begin
               next_r.st = IRSU_RST_HOLD;
            end else if (r.cnt == 5'(`IRSU_STARTUP_CYC - 1)) begin
               next_r.st = IRSU_RST_RUN;
            end
         end
         IRSU_RST_RUN: begin
            next_r.cnt = 5'd0;
            if (src) begin
               next_r.st = IRSU_RST_HOLD;
            end else if (r.wake) begin
               // Power-down wake: clock-counting delay only
               next_r.wake = 1'b0;
               next_r.st = IRSU_RST_DELAY;
               next_r.cnt = 5'(`IRSU_STARTUP_CYC - `IRSU_WAKE_CYC);
            end
         end
      endcase
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         r <= '{st: IRSU_RST_HOLD, cnt: 5'd0, low: 3'd0, wpulse: 1'b0, wake: 1'b0};
      end else begin
         r <= next_r;
      end
   end

   assign core_rst_o = (r.st != IRSU_RST_RUN) || r.wake;
   assign wdt_pulse_o = r.wpulse;
endmodule
`default_nettype wire

// ===== tb/irsu_props.sv
// Port-level checker for the interrupt, reset and status unit.
// Sees the top module's ports only; bound to it at the foot.
`default_nettype none
module irsu_props
   import irsu_pkg::*;
(
   input wire logic        CLOCK_I,
   input wire logic        NRST_I,
   input wire logic [10:0] IRQ_PEND_I,
   input wire logic [10:0] IRQ_ENABLE_I,
   input wire logic        IO_WR_I,
   input wire logic        CALL_I,
   input wire logic        RET_I,
   input wire logic        IRET_I,
   input wire logic        PUSH_I,
   input wire logic        IRQ_ACCEPT_I,
   input wire logic        WDT_EXPIRE_I,
   input wire logic        WDT_ENABLE_I,
   input wire logic [7:0]  STATUS_WORD_O,
   input wire logic [7:0]  STACK_PTR_O,
   input wire logic        IRQ_REQ_O,
   input wire logic [11:0] IRQ_VECTOR_O,
   input wire logic        IRQ_TAKEN_O,
   input wire logic        CORE_RESET_O,
   input wire logic [11:0] FETCH_ADDR_O,
   input wire logic        FETCH_LOAD_O,
   input wire logic        WDT_RESET_PULSE_O
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [11:0] low;
   logic        quiet;
   default clocking @(posedge CLOCK_I); endclocking
   default disable iff (!NRST_I);
   // Lowest enabled pending source
   always_comb begin
      low = 12'h000;
      for (int i = 10; i >= 0; i--) begin
         if (IRQ_PEND_I[i] && IRQ_ENABLE_I[i]) begin
            low = 12'(i + 1);
         end
      end
   end
   // No competing stack step
   assign quiet = !(CALL_I || RET_I || IRET_I || IO_WR_I || CORE_RESET_O || IRQ_ACCEPT_I);
   sequence s_take;
      IRQ_REQ_O && IRQ_ACCEPT_I;
   endsequence
   sequence s_entry;
      IRQ_TAKEN_O && FETCH_LOAD_O && !STATUS_WORD_O[7];
   endsequence
   AST_SIGN: assert property (STATUS_WORD_O[4] == (STATUS_WORD_O[2] ^ STATUS_WORD_O[3]))
      else $error("sign bit");
   AST_REQ: assert property (IRQ_REQ_O == (STATUS_WORD_O[7] && low != 0 && !CORE_RESET_O))
      else $error("request gating");
   AST_PRIO: assert property (IRQ_REQ_O |-> IRQ_VECTOR_O == low)
      else $error("vector choice");
   AST_ENTRY: assert property (s_take |=> s_entry ##0
      (FETCH_ADDR_O == $past(IRQ_VECTOR_O) && STACK_PTR_O == $past(STACK_PTR_O) - 8'h02))
      else $error("interrupt entry");
   AST_PUSH: assert property (PUSH_I && quiet |=> STACK_PTR_O == $past(STACK_PTR_O) - 8'h01)
      else $error("push step");
   AST_WDT: assert property (WDT_EXPIRE_I && WDT_ENABLE_I && !WDT_RESET_PULSE_O
      |=> WDT_RESET_PULSE_O ##1 !WDT_RESET_PULSE_O)
      else $error("watchdog pulse");
   AST_HOLD: assert property ($past(CORE_RESET_O) && CORE_RESET_O
      |-> STATUS_WORD_O == 8'h00 && STACK_PTR_O == 8'h00)
      else $error("reset hold");
   AST_FETCH: assert property ($fell(CORE_RESET_O)
      |-> ##[0:1] (FETCH_LOAD_O && FETCH_ADDR_O == 12'h000))
      else $error("restart fetch");
endmodule
bind irsu_top irsu_props u_props (.*);
`default_nettype wire

// ===== tb/irsu_core_model.sv
// Core model: accepts an offered interrupt after a set wait.
// Runs on the unit's clock; the bench switches it on and sets the wait.
`default_nettype none
module irsu_core_model (
   input  wire logic       clk_i,
   input  wire logic       on_i,
   input  wire logic [3:0] lat_i,
   input  wire logic       req_i,
   output var logic        accept_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] wait_cnt = 4'h0;
   initial accept_o = 1'b0;
   // Count offered cycles, then hold accept until the taking edge
   always @(posedge clk_i) begin
      if (!on_i || !req_i || accept_o) begin
         wait_cnt <= 4'h0;
         accept_o <= 1'b0;
      end else if (wait_cnt == lat_i) begin
         accept_o <= 1'b1;
      end else begin
         wait_cnt <= wait_cnt + 4'h1;
      end
   end
endmodule
`default_nettype wire

// ===== tb/interrupt_reset_status_unit_tb.sv
// Self-checking bench for the interrupt, reset and status unit.
// Bench names match the top's ports; a core model answers offers.
`include "irsu_params.svh"
`default_nettype none
module interrupt_reset_status_unit_tb;
   import irsu_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct {logic [8:0] o; logic [7:0] sp; logic g;} irsu_op_row_t;
   typedef struct {logic [10:0] p; logic [10:0] e; logic [11:0] v;} irsu_vec_row_t;
   typedef struct {logic [4:0] s; int n; logic f; logic w; logic x;} irsu_rst_row_t;
   logic        CLOCK_I = 0, NRST_I = 0, RESET_PIN_DISABLE_FUSE_I = 1, WDT_ENABLE_I = 0;
   logic        BIT_STORE_VAL_I = 0, IO_WR_I = 0, on = 0, IRQ_ACCEPT_I;
   logic [3:0]  lat = 0;
   logic [4:0]  src = 0, fl = 0;
   logic [8:0]  op = 0;
   logic [5:0]  IO_ADDR_I = 0;
   logic [7:0]  IO_WDATA_I = 0, IO_RDATA_O, STATUS_WORD_O, STACK_PTR_O;
   logic [10:0] IRQ_PEND_I = 0, IRQ_ENABLE_I = 0;
   logic [11:0] IRQ_VECTOR_O, FETCH_ADDR_O;
   logic        IRQ_REQ_O, IRQ_TAKEN_O, CORE_RESET_O, TSTORE_O, FETCH_LOAD_O, WDT_RESET_PULSE_O;
   wire logic   POR_I, RESET_PIN_I, WDT_EXPIRE_I, BROWNOUT_I, WAKE_POWERDOWN_I, FLAG_WR_I;
   wire logic   SET_GIE_I, CLR_GIE_I, IRET_I, RET_I, CALL_I, PUSH_I, POP_I, BIT_STORE_I;
   wire logic   FLAG_HALF_I, FLAG_OVF_I, FLAG_NEG_I, FLAG_ZERO_I, FLAG_CARRY_I;
   int          fails = 0, compares = 0, hi;
   irsu_op_row_t rows[8] = '{'{9'h001, 8'h80, 1}, '{9'h002, 8'h80, 0}, '{9'h020, 8'h7F, 0},
      '{9'h040, 8'h80, 0}, '{9'h008, 8'h7E, 0}, '{9'h010, 8'h80, 0}, '{9'h004, 8'h82, 1},
      '{9'h002, 8'h82, 0}};
   irsu_vec_row_t vrows[4] = '{'{11'h7FF, 11'h7FF, 12'h001}, '{11'h7FE, 11'h7FF, 12'h002},
      '{11'h401, 11'h400, 12'h00B}, '{11'h0FF, 11'h000, 12'h000}};
   irsu_rst_row_t rrows[8] = '{'{5'h02, 3, 1, 0, 1}, '{5'h08, 3, 1, 0, 1},
      '{5'h01, 10, 1, 0, 1}, '{5'h01, 10, 0, 0, 0}, '{5'h01, 1, 1, 0, 0},
      '{5'h04, 1, 1, 1, 1}, '{5'h04, 1, 1, 0, 0}, '{5'h10, 1, 1, 0, 1}};
   // Strobe, flag and reset-source fan-out
   assign {WAKE_POWERDOWN_I, BROWNOUT_I, WDT_EXPIRE_I, POR_I} = src[4:1];
   assign RESET_PIN_I = !src[0];
   assign {FLAG_WR_I, BIT_STORE_I, POP_I, PUSH_I} = op[8:5];
   assign {RET_I, CALL_I, IRET_I, CLR_GIE_I, SET_GIE_I} = op[4:0];
   assign {FLAG_HALF_I, FLAG_OVF_I, FLAG_NEG_I, FLAG_ZERO_I, FLAG_CARRY_I} = fl;
   irsu_top u_dut (.*);
   irsu_core_model u_core (
      .clk_i    (CLOCK_I),
      .on_i     (on),
      .lat_i    (lat),
      .req_i    (IRQ_REQ_O),
      .accept_o (IRQ_ACCEPT_I)
   );
   // 50 MHz clock
   initial begin
      forever #10 CLOCK_I = !CLOCK_I;
   end
   task automatic chk(input logic [11:0] got, input logic [11:0] exp);
      compares++;
      if (got !== exp) begin
         fails++;
         $display("BAD t=%0t got %h want %h", $time, got, exp);
      end
   endtask
   task automatic finish_test;
      $display("fails=%0d compares=%0d", fails, compares);
      if (fails == 0 && compares > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic pulse(input logic [8:0] o);
      @(posedge CLOCK_I);
      op <= o;
      @(posedge CLOCK_I);
      op <= 9'h000;
      #1;
   endtask
   task automatic io(input logic [5:0] a, input logic [7:0] d);
      @(posedge CLOCK_I);
      IO_WR_I <= 1'b1;
      IO_ADDR_I <= a;
      IO_WDATA_I <= d;
      @(posedge CLOCK_I);
      IO_WR_I <= 1'b0;
      #1;
   endtask
   task automatic settle;
      for (int i = 0; i < 100 && CORE_RESET_O !== 1'b0; i++) begin
         @(posedge CLOCK_I);
         #1;
      end
      chk(CORE_RESET_O, 0);
   endtask
   // Hang guard
   initial begin
      repeat (5000) @(posedge CLOCK_I);
      fails++;
      finish_test();
   end
   // Main sequence
   initial begin
      repeat (10) @(posedge CLOCK_I);
      NRST_I <= 1'b1;
      settle();
      chk(STATUS_WORD_O, 0);
      chk(FETCH_ADDR_O, 0);
      io(6'h3D, 8'h80);
      chk(IO_RDATA_O, 8'h80);
      io(6'h3B, 8'hFF);
      chk(IO_RDATA_O, 0);
      chk(STACK_PTR_O, 8'h80);
      io(6'h3F, 8'h0C);
      chk(STATUS_WORD_O, 8'h0C);
      io(6'h3F, 8'h04);
      chk(STATUS_WORD_O, 8'h14);
      for (int i = 0; i < 5; i++) begin
         @(posedge CLOCK_I);
         fl <= 5'(1 << i);
         pulse(9'h100);
         chk(STATUS_WORD_O, {2'b00, fl[4], fl[3] ^ fl[2], fl[3:0]});
      end
      for (int v = 1; v >= 0; v--) begin
         @(posedge CLOCK_I);
         BIT_STORE_VAL_I <= v[0];
         pulse(9'h080);
         chk(TSTORE_O, v[0]);
         chk(STATUS_WORD_O[6], v[0]);
      end
      foreach (rows[i]) begin
         pulse(rows[i].o);
         chk(STACK_PTR_O, rows[i].sp);
         chk(STATUS_WORD_O[7], rows[i].g);
      end
      pulse(9'h001);
      for (int i = 0; i < 15; i++) begin
         @(posedge CLOCK_I);
         IRQ_PEND_I <= (i < 4) ? vrows[i].p : 11'(1 << (i - 4));
         IRQ_ENABLE_I <= (i < 4) ? vrows[i].e : 11'(1 << (i - 4));
         #1;
         chk(IRQ_VECTOR_O, (i < 4) ? vrows[i].v : 12'(i - 3));
         chk(IRQ_REQ_O, i != 3);
      end
      pulse(9'h002);
      chk(IRQ_REQ_O, 0);
      for (int k = 0; k < 2; k++) begin
         @(posedge CLOCK_I);
         IRQ_PEND_I <= 11'h004;
         IRQ_ENABLE_I <= 11'h004;
         lat <= 4'(3 * k);
         on <= 1'b1;
         pulse(9'h001);
         for (int i = 0; i < 20 && IRQ_TAKEN_O !== 1'b1; i++) begin
            @(posedge CLOCK_I);
            #1;
         end
         chk(IRQ_TAKEN_O, 1);
         chk(FETCH_ADDR_O, 12'h003);
         chk(STATUS_WORD_O[7], 0);
         chk(STACK_PTR_O, 8'h80);
         @(posedge CLOCK_I);
         on <= 1'b0;
         IRQ_PEND_I <= 11'h000;
         pulse(9'h004);
         chk(STATUS_WORD_O[7], 1);
         chk(STACK_PTR_O, 8'h82);
      end
      foreach (rrows[i]) begin
         hi = 0;
         io(6'h3D, 8'h90);
         @(posedge CLOCK_I);
         RESET_PIN_DISABLE_FUSE_I <= rrows[i].f;
         WDT_ENABLE_I <= rrows[i].w;
         src <= rrows[i].s;
         repeat (rrows[i].n) @(posedge CLOCK_I);
         src <= 5'h00;
         repeat (60) begin
            @(posedge CLOCK_I);
            #1;
            hi += CORE_RESET_O;
         end
         chk(hi != 0, rrows[i].x);
         chk(STACK_PTR_O, rrows[i].x ? 8'h00 : 8'h90);
         if (rrows[i].x) begin
            chk(hi < `IRSU_STARTUP_CYC, rrows[i].s[4]);
         end
      end
      io(6'h3D, 8'h90);
      @(posedge CLOCK_I);
      NRST_I <= 1'b0;
      repeat (3) @(posedge CLOCK_I);
      #1;
      chk(STACK_PTR_O, 0);
      chk(CORE_RESET_O, 1);
      @(posedge CLOCK_I);
      NRST_I <= 1'b1;
      settle();
      finish_test();
   end
endmodule
`default_nettype wire
